// ### shared/mcs_consts.vh
/*
 Constants for the modem control and status register bank: register
 addresses, field positions, codes and reset values.
 Assumes inclusion by bare name from the design file.
*/
`ifndef MCS_CONSTS_VH
`define MCS_CONSTS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define MCS_ADDR_CTRL_A 2'h0
`define MCS_ADDR_CTRL_B 2'h1
`define MCS_ADDR_STATUS 2'h2
`define MCS_ADDR_TONE 2'h3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MCS_A_TEST 7
`define MCS_A_LOW_SPEED 5
`define MCS_A_MODE_HI 4
`define MCS_A_MODE_LO 2
`define MCS_A_TX_EN 1
`define MCS_A_ORIG 0
`define MCS_B_SRC_HI 7
`define MCS_B_SRC_LO 6
`define MCS_B_INT_EN 5
`define MCS_B_SCR_BYP 4
`define MCS_B_CLK_SEL 3
`define MCS_B_SOFT_RST 2
`define MCS_B_TEST_HI 1
`define MCS_B_TEST_LO 0
`define MCS_T_ANS 5
`define MCS_T_DUAL 4

// ----------------------------------------
// Transmit mode codes
// ----------------------------------------
`define MCS_MODE_PWRDN 3'h0
`define MCS_MODE_SYNC_INT 3'h1
`define MCS_MODE_SYNC_EXT 3'h2
`define MCS_MODE_SYNC_SLV 3'h3
`define MCS_MODE_ASYNC8 3'h4
`define MCS_MODE_ASYNC9 3'h5
`define MCS_MODE_ASYNC10 3'h6
`define MCS_MODE_ASYNC11 3'h7

// ----------------------------------------
// Transmit source and test codes
// ----------------------------------------
`define MCS_SRC_DATA 2'h0
`define MCS_SRC_ALT 2'h1
`define MCS_SRC_MARK 2'h2
`define MCS_SRC_SPACE 2'h3
`define MCS_TEST_NORMAL 2'h0
`define MCS_TEST_ALB 2'h1
`define MCS_TEST_RDL 2'h2
`define MCS_TEST_SELF 2'h3

// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define MCS_RESET_BYTE 8'h00
`define MCS_MASK_CTRL_A 8'hbf
`define MCS_MASK_TONE 8'h3f
`define MCS_STATUS_BITS 5

`endif

// ### rtl/mcs_modem_regs.v
/*
 Control, option and status register bank of a full-duplex line modem.
 Host reaches four 8-bit registers over a multiplexed address/data bus
 with address latch, chip select, read and write strobes (active low).
 Assumes all bus pins and line detector levels are asynchronous to clk
 and pass two flip-flops here; the analog core consumes the decoded
 control outputs.
*/
// Behaviour
// - Address 0..3 picks control A, B, status, tone
// - Control A bit 5 selects 300 or 1200
// - Mode 000 powerdown, 001 int sync, 010 ext
// - Modes 101,110,111 async 9,10,11 bits
// - Control A bit 1 enables transmitter
// - Control A bit 0 originate, else answer
// - Control B bits 7,6 pick transmit source
// - Control B bit 5 enables detect interrupt
// - Control B bit 4 set bypasses scrambler
// - Control B bit 3 picks clock output
// - Control B bits 1,0 test; bit 2 reset
// - Status bits 4..0 detect flags, top zero
// - Tone bit 5 answer, bit 4 dual tone
// - Tone bits 3..0 pick one of 16 pairs
// - Interrupt low on detect, released by read
// - Any detector change outside modem reset sets its status bit
// - Reset pin clears registers, clock to crystal
`timescale 1ns/1ps
`include "mcs_consts.vh"

module mcs_modem_regs (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Hardware reset pin, active high
   input wire hw_reset,
   // Host bus
   input wire ale,
   input wire cs_n,
   input wire rd_n,
   input wire wr_n,
   input wire [7:0] ad_in,
   output reg [7:0] ad_out,
   output reg ad_oe_n,
   output reg int_n,
   // Line detectors
   input wire [4:0] detect_in,
   // Decoded controls
   output reg low_speed,
   output reg [2:0] tx_mode,
   output reg sync_mode,
   output reg ext_timing,
   output reg slave_timing,
   output reg [3:0] char_bits,
   output reg power_down,
   output reg tx_enable,
   output reg originate_answer_select,
   output reg [1:0] tx_source,
   output reg scrambler_bypass,
   output reg clk_sel_baud,
   output reg [1:0] test_mode,
   output reg modem_reset,
   output reg send_answer_tone,
   output reg send_dual_tone,
   output reg [3:0] tone_code
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   reg [17:0] sync1_q;
   reg [17:0] sync2_q;
   wire [17:0] raw_in = {hw_reset, ale, cs_n, rd_n, wr_n, ad_in, detect_in};

   // Two stages; only the second stage feeds logic
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= 18'h0e000; // Strobes and select idle high
         sync2_q <= 18'h0e000;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   wire s_rst = sync2_q[17];
   wire s_ale = sync2_q[16];
   wire s_cs_n = sync2_q[15];
   wire s_rd_n = sync2_q[14];
   wire s_wr_n = sync2_q[13];
   wire [7:0] s_ad = sync2_q[12:5];
   wire [4:0] s_det = sync2_q[4:0];

   // ----------------------------------------
   // Strobe edges and address latch
   // ----------------------------------------
   reg ale_q;
   reg wr_n_q;
   reg rd_n_q;
   reg [1:0] addr_q;
   reg cs_lat_q;

   // Address and select caught on the falling edge of the latch enable
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ale_q <= 1'b0;
         wr_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         addr_q <= 2'h0;
         cs_lat_q <= 1'b0;
      end else begin
         ale_q <= s_ale;
         wr_n_q <= s_wr_n;
         rd_n_q <= s_rd_n;
         if (ale_q && !s_ale) begin
            addr_q <= s_ad[1:0];
            cs_lat_q <= !s_cs_n;
         end
      end
   end

   wire sel = cs_lat_q && !s_cs_n;
   wire wr_rise = sel && !wr_n_q && s_wr_n;
   wire rd_fall = sel && rd_n_q && !s_rd_n;
   wire rd_active = sel && !s_rd_n;

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   reg [7:0] ctrl_a_q;
   reg [7:0] ctrl_b_q;
   reg [7:0] tone_q;
   reg [4:0] status_q;
   reg [4:0] det_q;
   reg int_pend_q;

   // Write data taken on the rising edge of the write strobe
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_a_q <= `MCS_RESET_BYTE;
         ctrl_b_q <= `MCS_RESET_BYTE;
         tone_q <= `MCS_RESET_BYTE;
      end else if (s_rst) begin
         ctrl_a_q <= `MCS_RESET_BYTE;
         ctrl_b_q <= `MCS_RESET_BYTE;
         tone_q <= `MCS_RESET_BYTE;
      end else if (wr_rise) begin
         case (addr_q)
            `MCS_ADDR_CTRL_A: ctrl_a_q <= s_ad & `MCS_MASK_CTRL_A;
            `MCS_ADDR_CTRL_B: ctrl_b_q <= s_ad;
            `MCS_ADDR_TONE: tone_q <= s_ad & `MCS_MASK_TONE;
            default: ctrl_a_q <= ctrl_a_q; // Status is read only
         endcase
      end
   end

   // ----------------------------------------
   // Detect status and interrupt
   // ----------------------------------------
   wire [4:0] det_change = s_det ^ det_q;
   wire modem_rst = s_rst || ctrl_b_q[`MCS_B_SOFT_RST];

   // A change in the read cycle survives: set wins over clear
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         det_q <= 5'h00;
         status_q <= 5'h00;
         int_pend_q <= 1'b0;
      end else if (modem_rst) begin
         det_q <= s_det;
         status_q <= 5'h00;
         int_pend_q <= 1'b0;
      end else begin
         det_q <= s_det;
         if (rd_fall && addr_q == `MCS_ADDR_STATUS) begin
            status_q <= det_change;
            int_pend_q <= |det_change;
         end else begin
            status_q <= status_q | det_change;
            int_pend_q <= int_pend_q | (|det_change);
         end
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   reg [7:0] rd_data;

   always @* begin
      case (addr_q)
         `MCS_ADDR_CTRL_A: rd_data = ctrl_a_q;
         `MCS_ADDR_CTRL_B: rd_data = ctrl_b_q;
         `MCS_ADDR_STATUS: rd_data = {3'h0, status_q};
         `MCS_ADDR_TONE: rd_data = tone_q;
         default: rd_data = 8'h00;
      endcase
   end

   // ----------------------------------------
   // Transmit mode decode
   // ----------------------------------------
   function [3:0] mode_bits;
      input [2:0] m;
      begin
         case (m)
            `MCS_MODE_ASYNC8: mode_bits = 4'h8;
            `MCS_MODE_ASYNC9: mode_bits = 4'h9;
            `MCS_MODE_ASYNC10: mode_bits = 4'ha;
            `MCS_MODE_ASYNC11: mode_bits = 4'hb;
            default: mode_bits = 4'h0;
         endcase
      end
   endfunction

   wire [2:0] mode = ctrl_a_q[`MCS_A_MODE_HI:`MCS_A_MODE_LO];

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   // Transmit enable and tone sends are held low, and power down held high, while the modem is in reset
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ad_out <= 8'h00;
         ad_oe_n <= 1'b1;
         int_n <= 1'b1;
         low_speed <= 1'b0;
         tx_mode <= 3'h0;
         sync_mode <= 1'b0;
         ext_timing <= 1'b0;
         slave_timing <= 1'b0;
         char_bits <= 4'h0;
         power_down <= 1'b1;
         tx_enable <= 1'b0;
         originate_answer_select <= 1'b0;
         tx_source <= 2'h0;
         scrambler_bypass <= 1'b0;
         clk_sel_baud <= 1'b0;
         test_mode <= 2'h0;
         modem_reset <= 1'b1;
         send_answer_tone <= 1'b0;
         send_dual_tone <= 1'b0;
         tone_code <= 4'h0;
      end else begin
         ad_out <= rd_data;
         ad_oe_n <= !rd_active;
         int_n <= !(int_pend_q && ctrl_b_q[`MCS_B_INT_EN]);
         modem_reset <= modem_rst;
         low_speed <= ctrl_a_q[`MCS_A_LOW_SPEED];
         tx_mode <= mode;
         sync_mode <= mode == `MCS_MODE_SYNC_INT || mode == `MCS_MODE_SYNC_EXT
            || mode == `MCS_MODE_SYNC_SLV;
         ext_timing <= mode == `MCS_MODE_SYNC_EXT;
         slave_timing <= mode == `MCS_MODE_SYNC_SLV;
         char_bits <= mode_bits(mode);
         power_down <= modem_rst || mode == `MCS_MODE_PWRDN;
         tx_enable <= !modem_rst && ctrl_a_q[`MCS_A_TX_EN];
         originate_answer_select <= ctrl_a_q[`MCS_A_ORIG];
         tx_source <= ctrl_b_q[`MCS_B_SRC_HI:`MCS_B_SRC_LO];
         scrambler_bypass <= ctrl_b_q[`MCS_B_SCR_BYP];
         clk_sel_baud <= !s_rst && ctrl_b_q[`MCS_B_CLK_SEL];
         test_mode <= ctrl_b_q[`MCS_B_TEST_HI:`MCS_B_TEST_LO];
         send_answer_tone <= !modem_rst && tone_q[`MCS_T_ANS];
         send_dual_tone <= !modem_rst && tone_q[`MCS_T_DUAL];
         tone_code <= tone_q[3:0];
      end
   end

endmodule

// ### verification/mcs_regs_properties.sv
/* Port checker for the modem register bank.
 Assumes one clock domain and the two-flop input sync of the design. */
`timescale 1ns/1ps
module mcs_regs_chk (
   // Clock and reset
   input wire clk,
   input wire resetn,
   input wire hw_reset,
   // Host bus
   input wire rd_n,
   input wire wr_n,
   input wire ad_oe_n,
   input wire int_n,
   // Controls
   input wire [2:0] tx_mode,
   input wire sync_mode,
   input wire ext_timing,
   input wire slave_timing,
   input wire [3:0] char_bits,
   input wire power_down,
   input wire tx_enable,
   input wire modem_reset,
   input wire clk_sel_baud,
   input wire [3:0] tone_code
);
   // ----------------
   // Properties
   // ----------------
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Decodes register on the same edge as the mode field; checks still wait for two quiet edges
   mode_decode_a: assert property ($stable(tx_mode) [*2] |->
      sync_mode == (tx_mode inside {3'h1, 3'h2, 3'h3}) && ext_timing == (tx_mode == 3'h2)
      && slave_timing == (tx_mode == 3'h3)) else $error("mode decode wrong");
   char_len_a: assert property ($stable(tx_mode) [*2] |->
      char_bits == (tx_mode[2] ? {2'b10, tx_mode[1:0]} : 4'h0)) else $error("char length wrong");
   power_down_a: assert property (($stable(tx_mode) && $stable(modem_reset)) [*2] |->
      power_down == (tx_mode == 3'h0 || modem_reset)) else $error("power down wrong");
   tx_gate_a: assert property (modem_reset [*2] |-> !tx_enable)
      else $error("transmitter on in reset");
   hw_clear_a: assert property (hw_reset [*5] |-> modem_reset && tx_mode == 3'h0
      && !clk_sel_baud && tone_code == 4'h0) else $error("hardware reset left state");
   hw_int_a: assert property (hw_reset [*5] |-> int_n)
      else $error("interrupt held in reset");
   bus_idle_a: assert property (rd_n [*5] |-> ad_oe_n)
      else $error("bus driven without read");
   int_hold_a: assert property ((rd_n && wr_n && !hw_reset) [*5] ##0 !int_n |=> !int_n)
      else $error("interrupt dropped without read");
   // Main scenarios
   cover property (!int_n);
   cover property (!ad_oe_n);
   cover property (modem_reset && !hw_reset);
endmodule
bind mcs_modem_regs mcs_regs_chk i_mcs_regs_chk (.clk, .resetn, .hw_reset, .rd_n, .wr_n,
   .ad_oe_n, .int_n, .tx_mode, .sync_mode, .ext_timing, .slave_timing, .char_bits,
   .power_down, .tx_enable, .modem_reset, .clk_sel_baud, .tone_code);

// ### verification/mcs_host_model.sv
/* Host processor model for the multiplexed register bus.
 Assumes the bench calls one task at a time. */
`timescale 1ns/1ps
module mcs_host_model (
   // Clock
   input wire clk,
   // Bus
   output reg ale,
   output reg cs_n,
   output reg rd_n,
   output reg wr_n,
   output reg [7:0] ad_in,
   input wire [7:0] ad_out,
   input wire ad_oe_n
);
   // Idle bus from time zero
   initial begin
      ale = 1'b0;
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      ad_in = 8'h00;
   end
   // Move just after an edge, so no change races the sampling edge
   task step(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   // Falling ALE latches address and select
   task addr_phase(input [1:0] a);
      begin
         step(1);
         ale = 1'b1;
         cs_n = 1'b0;
         ad_in = {6'h00, a};
         step(3);
         ale = 1'b0;
         step(3);
      end
   endtask
   task write_reg(input [1:0] a, input [7:0] d);
      begin
         addr_phase(a);
         ad_in = d;
         wr_n = 1'b0;
         step(3);
         wr_n = 1'b1;
         step(3);
         cs_n = 1'b1;
         ad_in = ~d; // Stale data must not pass for valid
      end
   endtask
   task read_reg(input [1:0] a, output [7:0] d);
      integer n;
      begin
         addr_phase(a);
         ad_in = ~ad_in;
         rd_n = 1'b0;
         n = 0;
         while (ad_oe_n !== 1'b0 && n < 10) begin
            step(1);
            n = n + 1;
         end
         d = (ad_oe_n === 1'b0) ? ad_out : 8'hxx;
         rd_n = 1'b1;
         step(3);
         cs_n = 1'b1;
      end
   endtask
endmodule

// ### verification/tb_top.sv
/* Self-checking bench for the modem register bank.
 Host model drives the bus; the bench drives reset and detectors. */
`timescale 1ns/1ps
`define CHK(g, e) begin checks = checks + 1; if ((g) !== (e)) begin \
   fail_count = fail_count + 1; $display("ERROR %0t got %h want %h", $time, g, e); end end
module tb_top;
   reg clk, resetn, hw_reset;
   reg [4:0] detect_in;
   wire ale, cs_n, rd_n, wr_n, ad_oe_n, int_n, low_speed, sync_mode, ext_timing, slave_timing;
   wire power_down, tx_enable, originate_answer_select, scrambler_bypass, clk_sel_baud;
   wire modem_reset, send_answer_tone, send_dual_tone;
   wire [7:0] ad_in, ad_out;
   wire [3:0] char_bits, tone_code;
   wire [2:0] tx_mode;
   wire [1:0] tx_source, test_mode;
   wire [26:0] obs = {low_speed, tx_mode, sync_mode, ext_timing, slave_timing, char_bits,
      power_down, tx_enable, originate_answer_select, tx_source, scrambler_bypass,
      clk_sel_baud, test_mode, modem_reset, send_answer_tone, send_dual_tone, tone_code};
   // Rows: address, written byte, byte read back
   localparam [339:0] ROWS = {20'h00101, 20'h02626, 20'h00a0a, 20'h00c0c, 20'h01010,
      20'h01717, 20'h01818, 20'h03e3e, 20'h14141, 20'h18a8a, 20'h1f3f3, 20'h10404,
      20'h10000, 20'h3ff3f, 20'h32a2a, 20'h31515, 20'h2ff00};
   integer fail_count = 0, checks = 0, cycles = 0, i;
   reg [19:0] row;
   reg [7:0] sa, sb, st, rd;
   mcs_modem_regs i_mcs_modem_regs (.clk, .resetn, .hw_reset, .ale, .cs_n, .rd_n, .wr_n,
      .ad_in, .ad_out, .ad_oe_n, .int_n, .detect_in, .low_speed, .tx_mode, .sync_mode,
      .ext_timing, .slave_timing, .char_bits, .power_down, .tx_enable,
      .originate_answer_select, .tx_source, .scrambler_bypass, .clk_sel_baud, .test_mode,
      .modem_reset, .send_answer_tone, .send_dual_tone, .tone_code);
   mcs_host_model i_mcs_host_model (.clk, .ale, .cs_n, .rd_n, .wr_n, .ad_in, .ad_out, .ad_oe_n);
   // ----------------
   // Helpers
   // ----------------
   // Expected controls from register contents and the reset pin
   function [26:0] exp_obs(input [7:0] a, input [7:0] b, input [7:0] t, input hr);
      reg r;
      reg [2:0] m;
      begin
         r = b[2] | hr;
         m = a[4:2];
         exp_obs = {a[5], m, m != 3'h0 && !m[2], m == 3'h2, m == 3'h3,
            m[2] ? {2'b10, m[1:0]} : 4'h0, m == 3'h0 || r, a[1] & ~r, a[0],
            b[7:6], b[4], b[3] & ~hr, b[1:0], r, t[5] & ~r, t[4] & ~r, t[3:0]};
      end
   endfunction
   task wait_n(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task finish_test;
      begin
         $display("fail_count %0d checks %0d", fail_count, checks);
         if (fail_count == 0 && checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         finish_test;
      end
   end
   // ----------------
   // Sequence
   // ----------------
   initial begin
      resetn = 1'b0;
      hw_reset = 1'b0;
      detect_in = 5'h00;
      wait_n(3);
      resetn = 1'b1;
      wait_n(3);
      `CHK(ad_oe_n, 1'b1)
      for (i = 0; i < 4; i = i + 1) begin
         i_mcs_host_model.read_reg(i[1:0], rd);
         `CHK(rd, 8'h00)
      end
      sa = 8'h00;
      sb = 8'h00;
      st = 8'h00;
      for (i = 0; i < 17; i = i + 1) begin
         row = ROWS[(16 - i) * 20 +: 20];
         i_mcs_host_model.write_reg(row[17:16], row[15:8]);
         if (row[17:16] == 2'h0) sa = row[7:0];
         if (row[17:16] == 2'h1) sb = row[7:0];
         if (row[17:16] == 2'h3) st = row[7:0];
         i_mcs_host_model.read_reg(row[17:16], rd);
         `CHK(rd, row[7:0])
         `CHK(obs, exp_obs(sa, sb, st, 1'b0))
      end
      // Each detector change raises the interrupt; reading releases it
      i_mcs_host_model.write_reg(2'h1, 8'h20);
      for (i = 0; i < 5; i = i + 1) begin
         detect_in[i] = ~detect_in[i];
         wait_n(6);
         `CHK(int_n, 1'b0)
         i_mcs_host_model.read_reg(2'h2, rd);
         `CHK(rd, 8'h01 << i)
         wait_n(2);
         `CHK(int_n, 1'b1)
      end
      // Masked: flag still set, interrupt pin stays high
      i_mcs_host_model.write_reg(2'h1, 8'h00);
      detect_in[3] = ~detect_in[3];
      wait_n(6);
      `CHK(int_n, 1'b1)
      i_mcs_host_model.read_reg(2'h2, rd);
      `CHK(rd, 8'h08)
      // Reset pin clears a pending interrupt and the bank
      i_mcs_host_model.write_reg(2'h1, 8'h28);
      detect_in[0] = ~detect_in[0];
      wait_n(6);
      hw_reset = 1'b1;
      wait_n(6);
      `CHK(obs, exp_obs(8'h00, 8'h00, 8'h00, 1'b1))
      `CHK(int_n, 1'b1)
      hw_reset = 1'b0;
      wait_n(4);
      i_mcs_host_model.read_reg(2'h2, rd);
      `CHK(rd, 8'h00)
      finish_test;
   end
endmodule
